// [core/oms_pkg.sv]
// package: offsets, fields, reset values, modes and timing of the mode selector
package oms_pkg;
  // register port widths
  localparam int OMS_AW = 4;
  localparam int OMS_DW = 16;
  // register offsets, one word each
  localparam logic [3:0] OMS_A_CTRL      = 4'h0;
  localparam logic [3:0] OMS_A_BASE      = 4'h1;
  localparam logic [3:0] OMS_A_OFFS      = 4'h2;
  localparam logic [3:0] OMS_A_STBY_RED  = 4'h3;
  localparam logic [3:0] OMS_A_NIGHT_RED = 4'h4;
  localparam logic [3:0] OMS_A_FROST_SP  = 4'h5;
  localparam logic [3:0] OMS_A_DEAD_ZONE = 4'h6;
  localparam logic [3:0] OMS_A_STBY_INC  = 4'h7;
  localparam logic [3:0] OMS_A_NIGHT_INC = 4'h8;
  localparam logic [3:0] OMS_A_HEAT_SP   = 4'h9;
  localparam logic [3:0] OMS_A_EXT_TIME  = 4'ha;
  localparam logic [3:0] OMS_A_STATUS    = 4'hb;
  localparam logic [3:0] OMS_A_SETPT     = 4'hc;
  localparam int         OMS_NCFG        = 11;
  // control fields
  localparam int OMS_CTRL_OLD  = 0;
  localparam int OMS_CTRL_PBTN = 1;
  localparam int OMS_CTRL_COOL = 2;
  // status fields
  localparam int OMS_ST_MODE = 0;
  localparam int OMS_ST_PRES = 2;
  localparam int OMS_ST_WIN  = 3;
  localparam int OMS_ST_EXT  = 4;
  // reset values, temperatures in 0.01 K
  localparam logic [15:0] OMS_RST_CTRL      = 16'h0000;
  localparam logic [15:0] OMS_RST_BASE      = 16'h0834;
  localparam logic [15:0] OMS_RST_STBY_RED  = 16'h00c8;
  localparam logic [15:0] OMS_RST_NIGHT_RED = 16'h0190;
  localparam logic [15:0] OMS_RST_FROST_SP  = 16'h02bc;
  localparam logic [15:0] OMS_RST_DEAD_ZONE = 16'h00c8;
  localparam logic [15:0] OMS_RST_STBY_INC  = 16'h00c8;
  localparam logic [15:0] OMS_RST_NIGHT_INC = 16'h0190;
  localparam logic [15:0] OMS_RST_HEAT_SP   = 16'h0dac;
  localparam logic [15:0] OMS_RST_EXT_TIME  = 16'h0e10;
  // operating modes, gray order comfort-standby-night-frost
  typedef enum logic [1:0] {
    MODE_COMFORT = 2'h0,
    MODE_STANDBY = 2'h1,
    MODE_NIGHT   = 2'h3,
    MODE_FROST   = 2'h2
  } oms_mode_t;
  // one second tick for the comfort extension
  localparam longint OMS_CLK_NS   = 10;
  localparam longint OMS_SEC_NS   = 1000000000;
  localparam int     OMS_TICK_CYC = int'(OMS_SEC_NS / OMS_CLK_NS);
  localparam int     OMS_TICK_W   = 27;
  // reset value of a configuration word by index
  function automatic logic [15:0] oms_cfg_rst(input logic [3:0] idx);
    if (idx == OMS_A_BASE)           return OMS_RST_BASE;
    else if (idx == OMS_A_STBY_RED)  return OMS_RST_STBY_RED;
    else if (idx == OMS_A_NIGHT_RED) return OMS_RST_NIGHT_RED;
    else if (idx == OMS_A_FROST_SP)  return OMS_RST_FROST_SP;
    else if (idx == OMS_A_DEAD_ZONE) return OMS_RST_DEAD_ZONE;
    else if (idx == OMS_A_STBY_INC)  return OMS_RST_STBY_INC;
    else if (idx == OMS_A_NIGHT_INC) return OMS_RST_NIGHT_INC;
    else if (idx == OMS_A_HEAT_SP)   return OMS_RST_HEAT_SP;
    else if (idx == OMS_A_EXT_TIME)  return OMS_RST_EXT_TIME;
    else                             return OMS_RST_CTRL;
  endfunction
endpackage

// [core/oms_sp_if.sv]
// interface: mode and set point terms between selector and calculator
`timescale 1ns/10ps
`default_nettype none
interface oms_sp_if;
  import oms_pkg::*;
  logic               cool;
  oms_mode_t          mode;
  logic signed [15:0] base;
  logic signed [15:0] offset;
  logic signed [15:0] stby_red;
  logic signed [15:0] night_red;
  logic signed [15:0] frost_sp;
  logic signed [15:0] dead_zone;
  logic signed [15:0] stby_inc;
  logic signed [15:0] night_inc;
  logic signed [15:0] heat_sp;
  logic signed [15:0] setpoint;
  // selector side
  modport ctl (output cool, mode, base, offset, stby_red, night_red, frost_sp,
               output dead_zone, stby_inc, night_inc, heat_sp, input setpoint);
  // calculator side
  modport calc (input cool, mode, base, offset, stby_red, night_red, frost_sp,
                input dead_zone, stby_inc, night_inc, heat_sp, output setpoint);
endinterface
`default_nettype wire

// [core/oms_setpoint_calc.sv]
// current set point from mode, heating or cooling and configured terms
`timescale 1ns/10ps
`default_nettype none
module oms_setpoint_calc (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // terms in, set point out
  oms_sp_if.calc   sp
);
  import oms_pkg::*;

  logic signed [15:0] setpoint_ff;
  logic signed [15:0] nxt_setpoint;
  logic signed [15:0] rel_sp;

  ////////////////////////////////////////////////////////////////////////////
  // offset always on the base, never on the last result
  assign rel_sp = sp.base + sp.offset;

  // per mode selection of the set point
  always_comb begin
    nxt_setpoint = rel_sp;
    if (sp.mode == MODE_FROST) begin
      nxt_setpoint = sp.cool ? sp.heat_sp : sp.frost_sp;
    end else if (sp.cool) begin
      nxt_setpoint = rel_sp + sp.dead_zone;
      if (sp.mode == MODE_STANDBY) begin
        nxt_setpoint = rel_sp + sp.dead_zone + sp.stby_inc;
      end else if (sp.mode == MODE_NIGHT) begin
        nxt_setpoint = rel_sp + sp.dead_zone + sp.night_inc;
      end
    end else if (sp.mode == MODE_STANDBY) begin
      nxt_setpoint = rel_sp - sp.stby_red;
    end else if (sp.mode == MODE_NIGHT) begin
      nxt_setpoint = rel_sp - sp.night_red;
    end
  end

  // registered result
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      setpoint_ff <= 16'sh0000;
    end else begin
      setpoint_ff <= nxt_setpoint;
    end
  end

  assign sp.setpoint = setpoint_ff;

  ////////////////////////////////////////////////////////////////////////////
  heat_comfort_sp_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!sp.cool && sp.mode == MODE_COMFORT) |=>
      sp.setpoint == $past(sp.base) + $past(sp.offset))
    else $error("heating comfort set point wrong");
  heat_standby_sp_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!sp.cool && sp.mode == MODE_STANDBY) |=>
      sp.setpoint == $past(sp.base) + $past(sp.offset) - $past(sp.stby_red))
    else $error("heating standby set point wrong");
  frost_sp_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!sp.cool && sp.mode == MODE_FROST && $stable(sp.frost_sp)) |=>
      sp.setpoint == sp.frost_sp)
    else $error("frost set point not the configured one");
  cool_comfort_sp_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (sp.cool && sp.mode == MODE_COMFORT) |=>
      sp.setpoint == $past(sp.base) + $past(sp.offset) + $past(sp.dead_zone))
    else $error("cooling comfort set point wrong");
  heat_night_sp_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!sp.cool && sp.mode == MODE_NIGHT) |=>
      sp.setpoint == $past(sp.base) + $past(sp.offset) - $past(sp.night_red))
    else $error("heating night set point wrong");
endmodule
`default_nettype wire

// [core/oms_mode_select.sv]
// operating mode selection with presence handling and set point output
//
// Contract
// - preset, manual, scene; latest request wins, preset before manual before scene in one cycle
// - new scheme: open window frost overrides every other source; the old scheme ignores the window
// - presence button: new preset adopted, presence cleared
// - preset equal to pre-presence mode ignored
// - presence from night/frost ends after extension
// - presence from standby: comfort, no time limit
// - configuration picks new or old input scheme
// - new scheme: window 1 forces frost
// - new scheme: presence 1 gives comfort
// - new scheme: otherwise preset is the mode
// - old scheme: frost first, then comfort
// - old scheme: night object selects night, else standby
// - old frost object shared; window close clears frost
// - heating comfort: base plus offset
// - heating standby: base plus offset minus reduction
// - frost mode uses configured protection set point
// - offset applies to base, never accumulates
// - cooling comfort: base plus offset plus dead zone
`timescale 1ns/10ps
`default_nettype none
module oms_mode_select #(
  parameter int unsigned TICK_CYC = oms_pkg::OMS_TICK_CYC
) (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          arst_n,
  // register port
  input  wire logic [oms_pkg::OMS_AW-1:0]    reg_addr,
  input  wire logic [oms_pkg::OMS_DW-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output var  logic [oms_pkg::OMS_DW-1:0]    reg_rdata,
  // new scheme objects
  input  wire logic                          preset_stb,
  input  wire oms_pkg::oms_mode_t            preset_mode,
  input  wire logic                          presence_stb,
  input  wire logic                          presence_val,
  input  wire logic                          window_open,
  // local keys and scenes
  input  wire logic                          manual_stb,
  input  wire oms_pkg::oms_mode_t            manual_mode,
  input  wire logic                          scene_stb,
  input  wire oms_pkg::oms_mode_t            scene_mode,
  // old scheme objects
  input  wire logic                          old_night,
  input  wire logic                          old_comfort,
  input  wire logic                          old_frost,
  // results
  output var  oms_pkg::oms_mode_t            cur_mode,
  output var  logic signed [15:0]            cur_setpoint,
  output var  logic                          presence_on
);
  import oms_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // configuration words
  logic [15:0]           cfg_ff [0:OMS_NCFG-1];
  logic [OMS_DW-1:0]     rdata_ff;
  logic [OMS_DW-1:0]     nxt_rdata;
  // mode state
  oms_mode_t             mode_ff;
  oms_mode_t             nxt_mode;
  oms_mode_t             sel_mode_ff;
  oms_mode_t             pre_mode_ff;
  logic                  presence_ff;
  logic                  preset_ignore;
  logic                  preset_take;
  logic                  pbtn_clear;
  logic                  pres_rise;
  // comfort extension timer
  logic [OMS_TICK_W-1:0] tick_cnt_ff;
  logic                  tick;
  logic                  ext_run_ff;
  logic [15:0]           ext_cnt_ff;
  logic                  ext_expire;
  // set point calculator link
  oms_sp_if              sp_bus ();

  // configuration fields in use
  logic                  cfg_old;
  logic                  cfg_pbtn;
  logic                  cfg_cool;

  assign cfg_old  = cfg_ff[OMS_A_CTRL][OMS_CTRL_OLD];
  assign cfg_pbtn = cfg_ff[OMS_A_CTRL][OMS_CTRL_PBTN];
  assign cfg_cool = cfg_ff[OMS_A_CTRL][OMS_CTRL_COOL];

  // night and frost start the comfort extension when presence is set
  function automatic logic mode_is_long(input oms_mode_t m);
    return (m == MODE_NIGHT) || (m == MODE_FROST);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < OMS_NCFG; i++) begin
        cfg_ff[i] <= oms_cfg_rst(4'(i));
      end
    end else if (reg_wr && (reg_addr < 4'(OMS_NCFG))) begin
      cfg_ff[reg_addr] <= reg_wdata;
    end
  end

  // read decode, unmapped reads zero
  always_comb begin
    nxt_rdata = 16'h0000;
    if (!reg_rd) begin
      nxt_rdata = 16'h0000;
    end else if (reg_addr < 4'(OMS_NCFG)) begin
      nxt_rdata = cfg_ff[reg_addr];
    end else if (reg_addr == OMS_A_STATUS) begin
      nxt_rdata[OMS_ST_MODE +: 2] = mode_ff;
      nxt_rdata[OMS_ST_PRES]      = presence_ff;
      nxt_rdata[OMS_ST_WIN]       = window_open;
      nxt_rdata[OMS_ST_EXT]       = ext_run_ff;
    end else if (reg_addr == OMS_A_SETPT) begin
      nxt_rdata = sp_bus.setpoint;
    end
  end

  // read data for one cycle only
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // preset arbitration against presence
  assign preset_ignore = presence_ff && (preset_mode == pre_mode_ff);
  assign preset_take   = preset_stb && !preset_ignore;
  assign pbtn_clear    = cfg_pbtn && presence_ff && preset_take;
  assign pres_rise     = presence_stb && presence_val && !presence_ff;

  // requested mode, the newest request of three sources; preset before manual before scene in one cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sel_mode_ff <= MODE_COMFORT;
    end else if (preset_take) begin
      sel_mode_ff <= preset_mode;
    end else if (manual_stb) begin
      sel_mode_ff <= manual_mode;
    end else if (scene_stb) begin
      sel_mode_ff <= scene_mode;
    end
  end

  // presence flag, a set wins over any clear in the same cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      presence_ff <= 1'b0;
    end else if (presence_stb && presence_val) begin
      presence_ff <= 1'b1;
    end else if (presence_stb) begin
      presence_ff <= 1'b0;
    end else if (pbtn_clear) begin
      presence_ff <= 1'b0;
    end else if (ext_expire) begin
      presence_ff <= 1'b0;
    end
  end

  // requested mode at the moment presence was set
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pre_mode_ff <= MODE_COMFORT;
    end else if (pres_rise) begin
      pre_mode_ff <= sel_mode_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one second tick
  assign tick = (tick_cnt_ff == OMS_TICK_W'(TICK_CYC - 1));

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_ff <= '0;
    end else if (tick) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 1'b1;
    end
  end

  // comfort extension, seconds from the extension time word
  assign ext_expire = ext_run_ff && tick && (ext_cnt_ff <= 16'h0001);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ext_run_ff <= 1'b0;
      ext_cnt_ff <= 16'h0000;
    end else if (pres_rise) begin
      ext_run_ff <= mode_is_long(sel_mode_ff);
      ext_cnt_ff <= cfg_ff[OMS_A_EXT_TIME];
    end else if (!presence_ff || ext_expire) begin
      ext_run_ff <= 1'b0;
    end else if (ext_run_ff && tick) begin
      ext_cnt_ff <= ext_cnt_ff - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // current mode from the selected input scheme
  always_comb begin
    nxt_mode = sel_mode_ff;
    if (cfg_old) begin
      if (old_frost) begin
        nxt_mode = MODE_FROST;
      end else if (old_comfort) begin
        nxt_mode = MODE_COMFORT;
      end else if (old_night) begin
        nxt_mode = MODE_NIGHT;
      end else begin
        nxt_mode = MODE_STANDBY;
      end
    end else if (window_open) begin
      nxt_mode = MODE_FROST;
    end else if (presence_ff) begin
      nxt_mode = MODE_COMFORT;
    end else begin
      nxt_mode = sel_mode_ff;
    end
  end

  // two-bit mode register
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      mode_ff <= MODE_COMFORT;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // terms for the set point calculator
  assign sp_bus.cool      = cfg_cool;
  assign sp_bus.mode      = mode_ff;
  assign sp_bus.base      = $signed(cfg_ff[OMS_A_BASE]);
  assign sp_bus.offset    = $signed(cfg_ff[OMS_A_OFFS]);
  assign sp_bus.stby_red  = $signed(cfg_ff[OMS_A_STBY_RED]);
  assign sp_bus.night_red = $signed(cfg_ff[OMS_A_NIGHT_RED]);
  assign sp_bus.frost_sp  = $signed(cfg_ff[OMS_A_FROST_SP]);
  assign sp_bus.dead_zone = $signed(cfg_ff[OMS_A_DEAD_ZONE]);
  assign sp_bus.stby_inc  = $signed(cfg_ff[OMS_A_STBY_INC]);
  assign sp_bus.night_inc = $signed(cfg_ff[OMS_A_NIGHT_INC]);
  assign sp_bus.heat_sp   = $signed(cfg_ff[OMS_A_HEAT_SP]);

  // set point arithmetic
  oms_setpoint_calc u_calc (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .sp      (sp_bus.calc)
  );

  // outputs, all from flip-flops
  assign reg_rdata    = rdata_ff;
  assign cur_mode     = mode_ff;
  assign cur_setpoint = sp_bus.setpoint;
  assign presence_on  = presence_ff;

  ////////////////////////////////////////////////////////////////////////////
  // latest request wins
  manual_latest_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (manual_stb && !preset_stb) |=> sel_mode_ff == $past(manual_mode))
    else $error("manual request not taken");

  // open window held two cycles forces frost in the next cycle
  window_frost_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!cfg_old && window_open) [*2] |=> cur_mode == MODE_FROST [*1])
    else $error("open window did not force frost");

  // presence button adopts the new preset
  pbtn_adopt_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cfg_pbtn && presence_ff && preset_stb && !presence_stb
      && preset_mode != pre_mode_ff)
    |=> !presence_ff && sel_mode_ff == $past(preset_mode))
    else $error("presence button did not adopt preset");

  // repeated old preset is ignored
  preset_repeat_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (presence_ff && preset_stb && preset_mode == pre_mode_ff
      && !presence_stb && !ext_expire)
    |=> presence_ff && $stable(pre_mode_ff))
    else $error("repeated preset changed presence");

  // extension end clears presence
  ext_expire_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (ext_expire && !presence_stb) |=> !presence_ff ##1
      (cur_mode == $past(sel_mode_ff) || $past(cfg_old) || $past(window_open)))
    else $error("extension end did not clear presence");

  // night or frost presence loads the extension
  ext_start_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (pres_rise && mode_is_long(sel_mode_ff))
    |=> ext_run_ff && ext_cnt_ff == $past(cfg_ff[OMS_A_EXT_TIME]))
    else $error("extension not started");

  // presence object set wins over any clear
  presence_set_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (presence_stb && presence_val) |=> presence_on)
    else $error("presence object not taken");

  // standby presence starts no timer
  standby_no_timer_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (pres_rise && sel_mode_ff == MODE_STANDBY) |=> !ext_run_ff)
    else $error("timer started from standby");

  // new scheme presence gives comfort
  presence_comfort_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!cfg_old && !window_open && presence_ff) |=> cur_mode == MODE_COMFORT)
    else $error("presence did not give comfort");

  // new scheme preset passes straight through
  preset_direct_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!cfg_old && !window_open && !presence_ff) |=> cur_mode == $past(sel_mode_ff))
    else $error("preset not used as mode");

  // old frost object beats every other old object
  old_frost_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cfg_old && old_frost) |=> cur_mode == MODE_FROST)
    else $error("old frost object ignored");

  // old scheme priority
  old_scheme_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cfg_old && !old_frost && old_comfort) |=> cur_mode == MODE_COMFORT)
    else $error("old comfort object ignored");
  old_night_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cfg_old && !old_frost && !old_comfort)
    |=> cur_mode == ($past(old_night) ? MODE_NIGHT : MODE_STANDBY))
    else $error("old night or standby wrong");

  // frost from the shared object ends with it
  old_frost_clear_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cfg_old && $past(cfg_old) && $fell(old_frost)) |-> ##0 cur_mode == MODE_FROST ##1
      cur_mode != MODE_FROST)
    else $error("frost kept after shared object cleared");
endmodule
`default_nettype wire

// [verif/oms_bus_peer.sv]
// far-side model: bus devices sending mode objects as one-cycle telegrams
`timescale 1ns/10ps
`default_nettype none
module oms_bus_peer (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  // telegram request
  input  wire logic       go,
  input  wire logic [1:0] src,
  input  wire logic [1:0] val,
  // strobes preset, manual, scene, presence
  output var  logic [3:0] stb,
  output var  logic [1:0] obj_val
);
  // one source per telegram; value line toggles while idle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stb     <= 4'h0;
      obj_val <= 2'h0;
    end else begin
      stb     <= go ? (4'h1 << src) : 4'h0;
      obj_val <= go ? val : ~obj_val;
    end
  end
endmodule
`default_nettype wire

// [verif/oms_mode_select_tb.sv]
// self-checking bench for the operating mode selector
`timescale 1ns/10ps
`default_nettype none
module oms_mode_select_tb;
  import oms_pkg::*;
  logic        clk_sys = 1'b0, arst_n = 1'b0, go = 1'b0, cool = 1'b0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0, window_open = 1'b0;
  logic        old_night = 1'b0, old_comfort = 1'b0, old_frost = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [3:0]  stb, a_q = 4'h0;
  logic [1:0]  src = 2'h0, val = 2'h0, pv, cur_mode;
  logic [15:0] reg_wdata = 16'h0, off = 16'h0, reg_rdata, cur_setpoint;
  logic [31:0] q[$], n_q;
  logic        presence_on;
  int          fail_count = 0, total_checks = 0, cyc = 0, seed;
  localparam logic [15:0] RV [11] = '{OMS_RST_CTRL, OMS_RST_BASE, 16'h0, OMS_RST_STBY_RED,
    OMS_RST_NIGHT_RED, OMS_RST_FROST_SP, OMS_RST_DEAD_ZONE, OMS_RST_STBY_INC,
    OMS_RST_NIGHT_INC, OMS_RST_HEAT_SP, OMS_RST_EXT_TIME};
  localparam oms_mode_t MV [4] = '{MODE_COMFORT, MODE_STANDBY, MODE_NIGHT, MODE_FROST};
  always #5 clk_sys = ~clk_sys;
  ////////////////////
  oms_bus_peer u_peer (.clk_sys(clk_sys), .arst_n(arst_n), .go(go), .src(src), .val(val),
    .stb(stb), .obj_val(pv));
  oms_mode_select #(.TICK_CYC(10)) u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .preset_stb(stb[0]), .preset_mode(oms_mode_t'(pv)),
    .presence_stb(stb[3]), .presence_val(pv[0]), .window_open(window_open),
    .manual_stb(stb[1]), .manual_mode(oms_mode_t'(pv)), .scene_stb(stb[2]),
    .scene_mode(oms_mode_t'(pv)), .old_night(old_night), .old_comfort(old_comfort),
    .old_frost(old_frost), .cur_mode(cur_mode), .cur_setpoint(cur_setpoint),
    .presence_on(presence_on));
  ////////////////////
  // expected set point from mode and the terms written so far
  function automatic logic [15:0] exp_sp(input logic [1:0] m);
    logic [15:0] s;
    s = OMS_RST_BASE + off + (cool ? OMS_RST_DEAD_ZONE : 16'h0);
    if (m == MODE_STANDBY) s = cool ? s + OMS_RST_STBY_INC : s - OMS_RST_STBY_RED;
    if (m == MODE_NIGHT) s = cool ? s + OMS_RST_NIGHT_INC : s - OMS_RST_NIGHT_RED;
    if (m == MODE_FROST) s = cool ? OMS_RST_HEAT_SP : OMS_RST_FROST_SP;
    return s;
  endfunction
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read: note expectation and mask, monitor compares
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge clk_sys);
    reg_addr <= a; reg_rd <= 1'b1;
    q.push_back({e, m});
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  task automatic chk_mode(input logic [1:0] m, input logic p);
    rd(OMS_A_STATUS, {13'h0, p, m}, 16'h0007);
    rd(OMS_A_SETPT, exp_sp(m), 16'hffff);
  endtask
  // one telegram through the far-side model, then settle
  task automatic send(input logic [1:0] s, input logic [1:0] v);
    @(posedge clk_sys);
    go <= 1'b1; src <= s; val <= v;
    @(posedge clk_sys);
    go <= 1'b0;
    tk(5);
  endtask
  task automatic check_rd(input logic [15:0] d, input logic [31:0] n);
    total_checks++;
    if ((d & n[15:0]) !== (n[31:16] & n[15:0])) begin
      fail_count++;
      $display("[FAIL] %0t read %h expected %h", $time, d, n[31:16]);
    end
  endtask
  // direct outputs against the same note, under its mask
  task automatic check_out(input logic [15:0] d, input logic [31:0] n);
    total_checks++;
    if ((d & n[15:0]) !== (n[31:16] & n[15:0])) begin
      fail_count++;
      $display("[FAIL] %0t output %h expected %h", $time, d, n[31:16]);
    end
  endtask
  task automatic results();
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////
  // monitor: read data stand one cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_q) begin
      n_q = q.pop_front();
      check_rd(reg_rdata, n_q);
      if (a_q == OMS_A_STATUS) check_out({13'h0, presence_on, cur_mode}, n_q);
      if (a_q == OMS_A_SETPT) check_out(cur_setpoint, n_q);
    end
    rd_q <= reg_rd;
    a_q  <= reg_addr;
  end
  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      results();
    end
  end
  // main sequence
  initial begin
    seed = $urandom(41);
    tk(4);
    arst_n <= 1'b1;
    for (int i = 0; i < 11; i++) if (i != 2) rd(i[3:0], RV[i], 16'hffff);
    rd(4'hd, 16'h0, 16'hffff);
    chk_mode(MODE_COMFORT, 1'b0);
    off = 16'($urandom_range(400)) - 16'd200;
    wr(OMS_A_OFFS, off);
    wr(OMS_A_EXT_TIME, 16'h0002);
    for (int i = 0; i < 4; i++) begin
      send(2'(i % 3), MV[i]);
      chk_mode(MV[i], 1'b0);
    end
    send(2'h1, MODE_NIGHT);
    send(2'h2, MODE_STANDBY);
    chk_mode(MODE_STANDBY, 1'b0);
    send(2'h3, 2'h1);
    chk_mode(MODE_COMFORT, 1'b1);
    tk(40);
    chk_mode(MODE_COMFORT, 1'b1);
    send(2'h0, MODE_STANDBY);
    chk_mode(MODE_COMFORT, 1'b1);
    wr(OMS_A_CTRL, 16'h0002);
    send(2'h0, MODE_NIGHT);
    chk_mode(MODE_NIGHT, 1'b0);
    send(2'h3, 2'h1);
    chk_mode(MODE_COMFORT, 1'b1);
    tk(40);
    chk_mode(MODE_NIGHT, 1'b0);
    window_open <= 1'b1;
    tk(5);
    chk_mode(MODE_FROST, 1'b0);
    send(2'h0, MODE_COMFORT);
    chk_mode(MODE_FROST, 1'b0);
    window_open <= 1'b0;
    tk(5);
    chk_mode(MODE_COMFORT, 1'b0);
    wr(OMS_A_CTRL, 16'h0004);
    cool = 1'b1;
    tk(5);
    chk_mode(MODE_COMFORT, 1'b0);
    off = 16'($urandom_range(400)) - 16'd200;
    wr(OMS_A_OFFS, off);
    tk(5);
    chk_mode(MODE_COMFORT, 1'b0);
    send(2'h0, MODE_STANDBY);
    chk_mode(MODE_STANDBY, 1'b0);
    send(2'h1, MODE_NIGHT);
    chk_mode(MODE_NIGHT, 1'b0);
    send(2'h2, MODE_FROST);
    chk_mode(MODE_FROST, 1'b0);
    wr(OMS_A_CTRL, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      old_frost <= i[2]; old_comfort <= i[1]; old_night <= i[0];
      tk(4);
      rd(OMS_A_STATUS, i[2] ? MODE_FROST : i[1] ? MODE_COMFORT : i[0] ? MODE_NIGHT
        : MODE_STANDBY, 16'h0003);
    end
    // shared frost object released: frost must end
    old_frost <= 1'b0;
    old_comfort <= 1'b0;
    old_night <= 1'b0;
    tk(4);
    rd(OMS_A_STATUS, MODE_STANDBY, 16'h0003);
    tk(4);
    results();
  end
endmodule
`default_nettype wire
